//--- tsr_pkg.sv
// ==========================================================
// touch readout constants
package tsr_pkg;
	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_SEQ_CTRL  = 8'h69;
	localparam logic [7:0] IDX_SW_MUX    = 8'h6A;
	localparam logic [7:0] IDX_X_HIGH    = 8'h6B;
	localparam logic [7:0] IDX_Y_HIGH    = 8'h6C;
	localparam logic [7:0] IDX_LOW_PEN   = 8'h6D;
	localparam logic [7:0] IDX_Z_HIGH    = 8'h6E;
	localparam logic [7:0] IDX_IRQ_STAT  = 8'h70;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'h71;
	// switch and mux control fields
	localparam int SW_LSB       = 0;
	localparam int SW_MSB       = 3;
	localparam int PIN_LSB      = 4;
	localparam int PIN_MSB      = 5;
	localparam int MAN_BIT      = 6;
	localparam int REF_BIT      = 7;
	// sequence control fields
	localparam int AUTO_EN_BIT  = 0;
	localparam int SEQ_MODE_BIT = 2;
	// low bits register fields
	localparam int PEN_BIT      = 6;
	// interrupt bits
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_PEN_BIT  = 1;
	localparam int IRQ_BITS     = 2;
	// result layout
	localparam int RES_W        = 10;
	localparam int LOW_W        = 2;
	// switch order x plus, x minus, y plus, y minus
	localparam logic [3:0] SW_X_PAT   = 4'h3;
	localparam logic [3:0] SW_Y_PAT   = 4'hC;
	localparam logic [3:0] SW_Z_PAT   = 4'h6;
	localparam logic [3:0] SW_OPEN    = 4'h0;
	localparam logic [1:0] PIN_X_PLUS = 2'h0;
	localparam logic [1:0] PIN_Y_PLUS = 2'h1;
	localparam logic [7:0] RST_BYTE   = 8'h00;
	typedef enum logic [1:0] {MEAS_X, MEAS_Y, MEAS_Z} tsr_meas_t;
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT, ST_PEN} tsr_state_t;
endpackage : tsr_pkg

//--- tsr_touch_readout.sv
`timescale 1ns/1ns
// What this block does
// - control bits 0..3 close the four plate switches
// - mux bits 5:4 route plate pin, pick result
// - manual start without auto runs one conversion
// - manual start with auto runs one sequence
// - manual start bit clears when work completes
// - bit 7 selects reference touch pin or plates
// - reading x high latches x and y results
// - y high returns latched y top bits
// - low register holds two low bits each
// - low register bit 6 shows pen down
// - z high returns latest z top bits
// - sequence control bit 0 enables auto sequences
// - bit 2 picks x-y-z or x-only sequence
module tsr_touch_readout
	import tsr_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// panel and adc side
	output logic [3:0]       plate_switch_close,
	output logic [1:0]       plate_pin_select,
	output logic             reference_select,
	output logic             adc_start,
	input  wire logic        adc_done,
	input  wire logic [9:0]  adc_data,
	input  wire logic        pen_detect_pin,
	// interrupt
	output logic             irq
);
	// ==========================================================
	// decode helpers
	function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
		hit = (a[11:2] == {2'h0, idx}) && (a[1:0] == 2'h0);
	endfunction : hit

	function automatic logic mapped(input logic [11:0] a);
		mapped = hit(a, IDX_SEQ_CTRL) || hit(a, IDX_SW_MUX) || hit(a, IDX_X_HIGH)
			|| hit(a, IDX_Y_HIGH) || hit(a, IDX_LOW_PEN) || hit(a, IDX_Z_HIGH)
			|| hit(a, IDX_IRQ_STAT) || hit(a, IDX_IRQ_MASK);
	endfunction : mapped

	// ==========================================================
	// state
	logic [7:0]          seq_ctrl;
	logic [3:0]          ctrl_sw;
	logic [1:0]          ctrl_pin;
	logic                busy;
	logic                auto_run;
	tsr_state_t          state;
	tsr_meas_t           kind;
	logic [RES_W-1:0]    x_live;
	logic [RES_W-1:0]    y_live;
	logic [RES_W-1:0]    z_live;
	logic [RES_W-1:0]    y_hold;
	logic [RES_W-1:0]    x_hold;
	logic [IRQ_BITS-1:0] irq_stat;
	logic [IRQ_BITS-1:0] irq_mask;
	logic                pen_meta;
	logic                pen_sync;
	logic                pen_prev;
	logic [3:0]          next_sw;
	logic [1:0]          next_pin;
	logic                setup_ph;
	logic                wr_acc;
	logic                start_req;
	logic                conv_done;
	logic                work_done;

	assign setup_ph  = psel && !penable;
	assign wr_acc    = psel && penable && pwrite;
	assign start_req = wr_acc && hit(paddr, IDX_SW_MUX) && pwdata[MAN_BIT] && !busy;
	assign conv_done = (state == ST_WAIT) && adc_done;
	assign work_done = (conv_done && !auto_run)
		|| ((state == ST_PEN) && ((kind == MEAS_Z) || (kind == MEAS_X && seq_ctrl[SEQ_MODE_BIT])));
	assign pready    = 1'b1;
	assign irq       = |(irq_stat & irq_mask);

	// ==========================================================
	// pen pin synchroniser
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pen_meta <= 1'b0;
			pen_sync <= 1'b0;
			pen_prev <= 1'b0;
		end else begin
			pen_meta <= pen_detect_pin;
			pen_sync <= pen_meta;
			pen_prev <= pen_sync;
		end
	end

	// ==========================================================
	// control registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			seq_ctrl         <= RST_BYTE;
			ctrl_sw          <= SW_OPEN;
			ctrl_pin         <= PIN_X_PLUS;
			reference_select <= 1'b0;
			irq_mask         <= '0;
		end else if (wr_acc) begin
			if (hit(paddr, IDX_SEQ_CTRL)) begin
				seq_ctrl <= pwdata[7:0];
			end
			if (hit(paddr, IDX_SW_MUX)) begin
				ctrl_sw          <= pwdata[SW_MSB:SW_LSB];
				ctrl_pin         <= pwdata[PIN_MSB:PIN_LSB];
				reference_select <= pwdata[REF_BIT];
			end
			if (hit(paddr, IDX_IRQ_MASK)) begin
				irq_mask <= pwdata[IRQ_BITS-1:0];
			end
		end
	end

	// ==========================================================
	// measurement sequencer
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state    <= ST_IDLE;
			kind     <= MEAS_X;
			busy     <= 1'b0;
			auto_run <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_req) begin
						busy     <= 1'b1;
						auto_run <= seq_ctrl[AUTO_EN_BIT];
						kind     <= MEAS_X;
						state    <= ST_START;
					end
				end
				ST_START: begin
					state <= ST_WAIT;
				end
				ST_WAIT: begin
					if (adc_done) begin
						state <= auto_run ? ST_PEN : ST_IDLE;
					end
				end
				ST_PEN: begin
					if (work_done) begin
						state <= ST_IDLE;
					end else begin
						kind  <= (kind == MEAS_X) ? MEAS_Y : MEAS_Z;
						state <= ST_START;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
			if (work_done) begin
				busy     <= 1'b0;
				auto_run <= 1'b0;
			end
		end
	end

	// ==========================================================
	// plate drive
	always_comb begin
		next_sw  = ctrl_sw;
		next_pin = ctrl_pin;
		if (busy && auto_run) begin
			case (kind)
				MEAS_X: begin
					next_sw  = SW_X_PAT;
					next_pin = PIN_Y_PLUS;
				end
				MEAS_Y: begin
					next_sw  = SW_Y_PAT;
					next_pin = PIN_X_PLUS;
				end
				default: begin
					next_sw  = SW_Z_PAT;
					next_pin = PIN_X_PLUS;
				end
			endcase
			if (state == ST_PEN) begin
				next_sw = SW_OPEN;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			plate_switch_close <= SW_OPEN;
			plate_pin_select   <= PIN_X_PLUS;
			adc_start          <= 1'b0;
		end else begin
			plate_switch_close <= next_sw;
			plate_pin_select   <= next_pin;
			adc_start          <= (state == ST_IDLE && start_req) || (state == ST_PEN && !work_done);
		end
	end

	// ==========================================================
	// results
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			x_live <= '0;
			y_live <= '0;
			z_live <= '0;
		end else if (conv_done) begin
			if (auto_run) begin
				case (kind)
					MEAS_X:  x_live <= adc_data;
					MEAS_Y:  y_live <= adc_data;
					default: z_live <= adc_data;
				endcase
			end else if (ctrl_pin[0] == 1'b0) begin
				x_live <= adc_data;
			end else begin
				y_live <= adc_data;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			x_hold <= '0;
			y_hold <= '0;
		end else if (setup_ph && !pwrite && hit(paddr, IDX_X_HIGH)) begin
			x_hold <= x_live;
			y_hold <= y_live;
		end
	end

	// ==========================================================
	// interrupt status
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_stat <= '0;
		end else begin
			for (int i = 0; i < IRQ_BITS; i++) begin
				if (wr_acc && hit(paddr, IDX_IRQ_STAT) && pwdata[i]) begin
					irq_stat[i] <= 1'b0;
				end
			end
			if (work_done) begin
				irq_stat[IRQ_DONE_BIT] <= 1'b1;
			end
			if (pen_sync && !pen_prev) begin
				irq_stat[IRQ_PEN_BIT] <= 1'b1;
			end
		end
	end

	// ==========================================================
	// apb read data
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (setup_ph) begin
			pslverr <= !mapped(paddr);
			prdata  <= '0;
			if (!pwrite) begin
				if (hit(paddr, IDX_SEQ_CTRL)) begin
					prdata[7:0] <= seq_ctrl;
				end
				if (hit(paddr, IDX_SW_MUX)) begin
					prdata[7:0] <= {reference_select, busy, ctrl_pin, ctrl_sw};
				end
				if (hit(paddr, IDX_X_HIGH)) begin
					prdata[7:0] <= x_live[RES_W-1:LOW_W];
				end
				if (hit(paddr, IDX_Y_HIGH)) begin
					prdata[7:0] <= y_hold[RES_W-1:LOW_W];
				end
				if (hit(paddr, IDX_LOW_PEN)) begin
					prdata[7:0] <= {1'b0, pen_sync, z_live[LOW_W-1:0], y_hold[LOW_W-1:0],
						x_hold[LOW_W-1:0]};
				end
				if (hit(paddr, IDX_Z_HIGH)) begin
					prdata[7:0] <= z_live[RES_W-1:LOW_W];
				end
				if (hit(paddr, IDX_IRQ_STAT)) begin
					prdata[IRQ_BITS-1:0] <= irq_stat;
				end
				if (hit(paddr, IDX_IRQ_MASK)) begin
					prdata[IRQ_BITS-1:0] <= irq_mask;
				end
			end
		end
	end

	// ==========================================================
	// checks
	a_switch_follow: assert property (@(posedge clk) disable iff (sys_rst)
		(!busy && !$past(busy)) |-> plate_switch_close == $past(ctrl_sw))
		else $error("switch outputs do not follow control bits");

	a_manual_route: assert property (@(posedge clk) disable iff (sys_rst)
		(conv_done && !auto_run && !ctrl_pin[0]) |=> x_live == $past(adc_data))
		else $error("manual x plate result not stored as x");

	a_single_start: assert property (@(posedge clk) disable iff (sys_rst)
		(start_req && !seq_ctrl[AUTO_EN_BIT]) |=> adc_start ##1 (!adc_start && state == ST_WAIT))
		else $error("manual measurement started more than once");

	a_auto_pattern: assert property (@(posedge clk) disable iff (sys_rst)
		(auto_run && state == ST_WAIT && kind == MEAS_X) |-> plate_switch_close == SW_X_PAT)
		else $error("auto x measurement uses wrong switches");

	a_start_clear: assert property (@(posedge clk) disable iff (sys_rst)
		work_done |=> !busy && state == ST_IDLE)
		else $error("manual start bit not cleared at completion");

	a_hold_coherent: assert property (@(posedge clk) disable iff (sys_rst)
		(setup_ph && !pwrite && hit(paddr, IDX_X_HIGH)) |=> y_hold == $past(y_live)
		&& prdata[7:0] == x_hold[RES_W-1:LOW_W])
		else $error("x high read did not latch a coherent set");

	a_auto_arm: assert property (@(posedge clk) disable iff (sys_rst)
		(start_req && seq_ctrl[AUTO_EN_BIT]) |=> auto_run && state == ST_START)
		else $error("auto sequence not armed by manual start");

	a_x_only: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_PEN && seq_ctrl[SEQ_MODE_BIT]) |=> state == ST_IDLE)
		else $error("x only sequence ran past one measurement");

	a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
		work_done |=> irq_stat[IRQ_DONE_BIT] && (irq || !irq_mask[IRQ_DONE_BIT]))
		else $error("completion did not raise interrupt");
endmodule : tsr_touch_readout

//--- tsr_adc_model.sv
`timescale 1ns/1ns
// ====================
// adc and panel stand-in
module tsr_adc_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// from readout, lat from the bench
	input  wire logic       adc_start,
	input  wire logic [3:0] plate_switch_close,
	input  wire logic [1:0] plate_pin_select,
	input  wire logic [3:0] lat,
	// to readout, start_count to the bench
	output logic            adc_done,
	output logic [9:0]      adc_data,
	output logic [7:0]      start_count
);
	logic       busy;
	logic [3:0] cnt;
	// result encodes switches, pin and conversion number
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy        <= 1'b0;
			cnt         <= 4'h0;
			adc_done    <= 1'b0;
			adc_data    <= 10'h155;
			start_count <= 8'h00;
		end else begin
			adc_done <= 1'b0;
			// data not valid between results, keep it moving
			adc_data <= ~adc_data;
			if (busy && cnt == 4'h0) begin
				adc_done <= 1'b1;
				adc_data <= {plate_switch_close, plate_pin_select, start_count[3:0]};
				busy     <= 1'b0;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
			end
			if (adc_start) begin
				busy        <= 1'b1;
				cnt         <= lat;
				start_count <= start_count + 8'h01;
			end
		end
	end
endmodule : tsr_adc_model

//--- tsr_touch_readout_test.sv
`timescale 1ns/1ns
// ====================
// readout bench
module tsr_touch_readout_test;
	import tsr_pkg::*;
	logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, ref_sel, e;
	logic        adc_start, adc_done, pen, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  sw, lat;
	logic [1:0]  pin;
	logic [9:0]  adc_data, ey;
	logic [7:0]  sc, c0;
	int          n_mismatch = 0, compares = 0, cyc = 0;

	tsr_touch_readout tsr_touch_readout_i (.clk(clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .plate_switch_close(sw), .plate_pin_select(pin),
		.reference_select(ref_sel), .adc_start(adc_start), .adc_done(adc_done),
		.adc_data(adc_data), .pen_detect_pin(pen), .irq(irq));
	tsr_adc_model tsr_adc_model_i (.clk(clk), .sys_rst(sys_rst), .adc_start(adc_start),
		.plate_switch_close(sw), .plate_pin_select(pin), .lat(lat), .adc_done(adc_done),
		.adc_data(adc_data), .start_count(sc));

	// ====================
	// shared tasks
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		compares++;
		if (got !== ex) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {2'h0, idx, 2'h0};
		pwdata  <= {24'h0, wd};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] ex);
		apb(1'b0, idx, 8'h00);
		chk(nm, {24'h0, ex}, r);
	endtask : rd

	task automatic irq_chk(input logic ex);
		@(negedge clk);
		chk("irq", {31'h0, ex}, {31'h0, irq});
		@(posedge clk);
	endtask : irq_chk

	task automatic wait_done;
		for (int i = 0; i < 40; i++) begin
			apb(1'b0, IDX_SW_MUX, 8'h00);
			if (r[MAN_BIT] === 1'b0) break;
		end
		chk("start bit", 32'h0, {31'h0, r[MAN_BIT]});
	endtask : wait_done

	// ====================
	// scenarios
	task automatic test_regs;
		chk("switch reset", 32'h0, {28'h0, sw});
		rd("seq reset", IDX_SEQ_CTRL, RST_BYTE);
		rd("mask reset", IDX_IRQ_MASK, RST_BYTE);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, IDX_SW_MUX, 8'h80 | (8'h01 << i) | 8'(i << 4));
			@(negedge clk);
			chk("switches", 32'(4'h1 << i), {28'h0, sw});
			chk("pin", i, {30'h0, pin});
			chk("reference", 32'h1, {31'h0, ref_sel});
			@(posedge clk);
			rd("mux back", IDX_SW_MUX, 8'h80 | (8'h01 << i) | 8'(i << 4));
		end
		apb(1'b1, IDX_SW_MUX, 8'h00);
		chk("reference off", 32'h0, {31'h0, ref_sel});
		apb(1'b0, 8'h60, 8'h00);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		$display("test regs done");
	endtask : test_regs

	task automatic test_manual;
		logic [9:0] ex;
		for (int p = 0; p < 4; p++) begin
			lat <= 4'(p * 3 + 1);
			c0 = sc;
			apb(1'b1, IDX_SW_MUX, 8'h45 | 8'(p << 4));
			wait_done();
			chk("conversions", 32'h1, 32'(sc - c0));
			ex = {4'h5, 2'(p), 4'(c0 + 8'h1)};
			apb(1'b0, IDX_X_HIGH, 8'h00);
			if (!p[0]) chk("x high", 32'(ex[9:2]), r);
			apb(1'b0, IDX_Y_HIGH, 8'h00);
			if (p[0]) chk("y high", 32'(ex[9:2]), r);
			apb(1'b0, IDX_LOW_PEN, 8'h00);
			chk("low bits", 32'(ex[1:0]), 32'(p[0] ? r[3:2] : r[1:0]));
			rd("done event", IDX_IRQ_STAT, 8'h01);
			apb(1'b1, IDX_IRQ_STAT, 8'h01);
		end
		$display("test manual done");
	endtask : test_manual

	task automatic test_auto(input logic mode, input int n);
		logic [9:0] ex, ez;
		apb(1'b1, IDX_SEQ_CTRL, {5'h0, mode, 2'h1});
		c0 = sc;
		apb(1'b1, IDX_SW_MUX, 8'h7F);
		wait_done();
		chk("sequence length", n, 32'(sc - c0));
		ex = {SW_X_PAT, PIN_Y_PLUS, 4'(c0 + 8'h1)};
		rd("auto x high", IDX_X_HIGH, ex[9:2]);
		if (!mode) begin
			ey = {SW_Y_PAT, PIN_X_PLUS, 4'(c0 + 8'h2)};
			ez = {SW_Z_PAT, PIN_X_PLUS, 4'(c0 + 8'h3)};
			rd("auto y high", IDX_Y_HIGH, ey[9:2]);
			rd("auto low", IDX_LOW_PEN, {2'h0, ez[1:0], ey[1:0], ex[1:0]});
			rd("auto z high", IDX_Z_HIGH, ez[9:2]);
		end
		apb(1'b1, IDX_SEQ_CTRL, 8'h00);
		$display("test auto done");
	endtask : test_auto

	task automatic test_latch;
		apb(1'b0, IDX_X_HIGH, 8'h00);
		c0 = sc;
		apb(1'b1, IDX_SW_MUX, 8'h55);
		wait_done();
		rd("held y high", IDX_Y_HIGH, ey[9:2]);
		apb(1'b0, IDX_LOW_PEN, 8'h00);
		chk("held y low", 32'(ey[1:0]), 32'(r[3:2]));
		ey = {4'h5, 2'h1, 4'(c0 + 8'h1)};
		apb(1'b0, IDX_X_HIGH, 8'h00);
		rd("new y high", IDX_Y_HIGH, ey[9:2]);
		apb(1'b1, IDX_IRQ_STAT, 8'h03);
		$display("test latch done");
	endtask : test_latch

	task automatic test_irq;
		pen <= 1'b1;
		repeat (4) @(posedge clk);
		apb(1'b0, IDX_LOW_PEN, 8'h00);
		chk("pen down", 32'h1, {31'h0, r[PEN_BIT]});
		chk("reserved", 32'h0, {31'h0, r[7]});
		rd("pen event", IDX_IRQ_STAT, 8'h02);
		irq_chk(1'b0);
		apb(1'b1, IDX_IRQ_MASK, 8'h02);
		irq_chk(1'b1);
		apb(1'b1, IDX_IRQ_STAT, 8'h02);
		irq_chk(1'b0);
		pen <= 1'b0;
		rd("event cleared", IDX_IRQ_STAT, 8'h00);
		$display("test irq done");
	endtask : test_irq

	task automatic end_sim;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim

	// ====================
	// clock, reset, sequence
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end

	initial begin
		sys_rst = 1'b1;
		{psel, penable, pwrite, pen} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		lat = 4'h1;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		test_regs();
		test_manual();
		test_auto(1'b1, 1);
		test_auto(1'b0, 3);
		test_latch();
		test_irq();
		end_sim();
	end
endmodule : tsr_touch_readout_test
